// [hw/exc_params.svh]
// constants for the thread exception and notification block
`ifndef EXC_PARAMS_SVH
`define EXC_PARAMS_SVH

// ****************************************************************
// register type and subregister codes
// ****************************************************************
`define REGTYPE_W 4
`define SUBREG_W 5
`define REGTYPE_CTRL 4'h8
`define REGTYPE_NOTIFY 4'h9
`define SUB_WORD0 5'h00
`define SUB_WORD1 5'h04
`define SUB_WORD2 5'h08

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_SINGLE_FLOAT_MODE_BIT 0
`define BIT_MASTER 31
`define BIT_ST_HALT 30
`define BIT_ST_SW 29
`define BIT_ST_ILLEGAL 28
`define BIT_ST_STACK 27
`define BIT_EN_BKPT 15
`define BIT_EN_SW 13
`define BIT_EN_ILLEGAL 12
`define BIT_EN_STACK 11
`define AIP_LSB 3
`define AIP_W 29

// ****************************************************************
// widths and reset values
// ****************************************************************
`define DATA_W 32
`define THREAD_CNT_W 16
`define HOST_CNT_W 1
`define NOTIFY_N 3
`define WORD_RESET 32'h0000_0000
`define AIP_ONE 29'h0000_0001

`endif

// [hw/exc_pkg.sv]
// shared types for the thread exception and notification block
`include "exc_params.svh"

package exc_pkg;

  // architecture register access from the instruction pipeline
  typedef struct packed {
    logic valid;
    logic write;
    logic restore;
    logic [`REGTYPE_W-1:0] regtype;
    logic [`SUBREG_W-1:0] subreg;
    logic [`DATA_W-1:0] wdata;
  } arf_req_s;

  // initial thread state from the dispatcher
  typedef struct packed {
    logic valid;
    logic single_float_mode_bit;
    logic bkpt_en;
    logic sw_en;
    logic illegal_en;
    logic stack_en;
  } dispatch_s;

  // exception events from the pipeline
  typedef struct packed {
    logic bkpt;
    logic ext_halt;
    logic illegal;
    logic stack_ovf;
  } exc_event_s;

  typedef enum logic [1:0] {
    SEL_THREAD_A,
    SEL_HOST,
    SEL_THREAD_B
  } notify_sel_e;

endpackage

// [hw/notify_counter.sv]
// one notification count with wait consumption and stall tracking
`timescale 1ns/100ps
`include "exc_params.svh"

module notify_counter #(
  parameter int WIDTH = `THREAD_CNT_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // events
  input wire logic notify,
  input wire logic wait_req,
  // context restore
  input wire logic restore_wr,
  input wire logic [WIDTH-1:0] restore_data,
  // state
  output logic [WIDTH-1:0] count_ff,
  output logic stall_ff
);

  logic at_max;

  assign at_max = &count_ff;

  // ****************************************************************
  // count
  // ****************************************************************
  // a notification that meets a waiting thread is consumed at once,
  // so the count stays at zero and the thread is released
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_ff <= '0;
    end else if (restore_wr) begin
      count_ff <= restore_data;
    end else if (wait_req && count_ff != '0 && !notify) begin
      count_ff <= count_ff - 1'b1;
    end else if (notify && !stall_ff && !at_max &&
                 !(wait_req && count_ff == '0)) begin
      count_ff <= count_ff + 1'b1;
    end
  end

  // ****************************************************************
  // stall
  // ****************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stall_ff <= 1'b0;
    end else if (notify) begin
      stall_ff <= 1'b0;
    end else if (wait_req && count_ff == '0) begin
      stall_ff <= 1'b1;
    end
  end

endmodule

// [hw/thread_exception_and_notify_regs.sv]
// per-thread exception control and notification registers
`timescale 1ns/100ps
`include "exc_params.svh"

module thread_exception_and_notify_regs
  import exc_pkg::*;
#(
  parameter int THREAD_W = `THREAD_CNT_W,
  parameter int HOST_W = `HOST_CNT_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // register access from the pipeline
  input wire arf_req_s arf_req,
  output logic [`DATA_W-1:0] rd_data_ff,
  output logic rd_valid_ff,
  // dispatcher
  input wire dispatch_s dispatch,
  // exception events and pointers
  input wire exc_event_s exc_event,
  input wire logic [`DATA_W-1:0] instruction_pointer,
  input wire logic [`DATA_W-1:0] system_routine_entry_pointer,
  // redirect of the instruction pointer
  output logic ip_load_ff,
  output logic [`DATA_W-1:0] ip_load_addr_ff,
  // thread state
  output logic exc_mode_ff,
  output logic single_float_mode_bit_ff,
  output logic msg_float_sideband_ff,
  // notification
  input wire logic [`NOTIFY_N-1:0] notify_in,
  input wire logic wait_valid,
  input wire notify_sel_e wait_sel,
  output logic [`NOTIFY_N-1:0] wait_stall
);

  // ****************************************************************
  // decode
  // ****************************************************************
  logic ctrl_sel;
  logic notify_sel;
  logic wr_word0;
  logic wr_word1;
  logic wr_word2;
  logic nt_wr;
  logic sub_known;

  assign ctrl_sel = arf_req.valid && arf_req.regtype == `REGTYPE_CTRL;
  assign notify_sel = arf_req.valid &&
                      arf_req.regtype == `REGTYPE_NOTIFY;
  assign sub_known = arf_req.subreg == `SUB_WORD0 ||
                     arf_req.subreg == `SUB_WORD1 ||
                     arf_req.subreg == `SUB_WORD2;
  assign wr_word0 = ctrl_sel && arf_req.write &&
                    arf_req.subreg == `SUB_WORD0;
  assign wr_word1 = ctrl_sel && arf_req.write &&
                    arf_req.subreg == `SUB_WORD1;
  assign wr_word2 = ctrl_sel && arf_req.write &&
                    arf_req.subreg == `SUB_WORD2;
  // writes reach the counts only during context restore
  assign nt_wr = notify_sel && arf_req.write && arf_req.restore;

  // ****************************************************************
  // state
  // ****************************************************************
  logic st_halt_ff;
  logic st_sw_ff;
  logic st_illegal_ff;
  logic st_stack_ff;
  logic en_bkpt_ff;
  logic en_sw_ff;
  logic en_illegal_ff;
  logic en_stack_ff;
  logic [`AIP_W-1:0] aip_ff;

  // ****************************************************************
  // exception entry
  // ****************************************************************
  logic sw_raise;
  logic take_sync;
  logic take_sw;
  logic take;
  logic ret;
  logic [`AIP_W-1:0] ip_field;
  logic [`AIP_W-1:0] nxt_aip;

  // clearing the bit while in application code does nothing
  assign sw_raise = wr_word1 && arf_req.wdata[`BIT_ST_SW] &&
                    !exc_mode_ff;
  assign take_sync = (exc_event.bkpt && en_bkpt_ff) ||
                     (exc_event.illegal && en_illegal_ff) ||
                     (exc_event.stack_ovf && en_stack_ff) ||
                     exc_event.ext_halt;
  assign take_sw = sw_raise && en_sw_ff;
  // handler code is never re-entered; its events are only recorded, except a breakpoint, which is dropped
  assign take = !exc_mode_ff && (take_sync || take_sw);
  assign ret = wr_word0 && !arf_req.wdata[`BIT_MASTER] &&
               exc_mode_ff;
  assign ip_field = instruction_pointer[`DATA_W-1:`AIP_LSB];
  // an instruction-bound event keeps its own pointer; a lone software
  // exception resumes after the instruction that raised it
  assign nxt_aip = take_sync ? ip_field :
                   ip_field + `AIP_ONE;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      aip_ff <= '0;
    end else if (take) begin
      aip_ff <= nxt_aip;
    end else if (wr_word2) begin
      aip_ff <= arf_req.wdata[`DATA_W-1:`AIP_LSB];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      exc_mode_ff <= 1'b0;
    end else if (take) begin
      exc_mode_ff <= 1'b1;
    end else if (ret) begin
      exc_mode_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ip_load_ff <= 1'b0;
      ip_load_addr_ff <= `WORD_RESET;
    end else begin
      ip_load_ff <= take || ret;
      if (take) begin
        ip_load_addr_ff <= system_routine_entry_pointer;
      end else if (ret) begin
        ip_load_addr_ff <= {aip_ff, {`AIP_LSB{1'b0}}};
      end
    end
  end

  // ****************************************************************
  // status bits
  // ****************************************************************
  // hardware sets after the software write so a set wins a clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_halt_ff <= 1'b0;
      st_sw_ff <= 1'b0;
      st_illegal_ff <= 1'b0;
      st_stack_ff <= 1'b0;
    end else begin
      if (wr_word1) begin
        st_halt_ff <= arf_req.wdata[`BIT_ST_HALT];
        st_illegal_ff <= arf_req.wdata[`BIT_ST_ILLEGAL];
        st_stack_ff <= arf_req.wdata[`BIT_ST_STACK];
        // a zero in application code leaves the bit alone
        if (exc_mode_ff || arf_req.wdata[`BIT_ST_SW]) begin
          st_sw_ff <= arf_req.wdata[`BIT_ST_SW];
        end
      end
      if (exc_event.ext_halt) begin
        st_halt_ff <= 1'b1;
      end
      // leftover status raises nothing: only events feed entry
      if (exc_event.illegal) begin
        st_illegal_ff <= 1'b1;
      end
      if (exc_event.stack_ovf) begin
        st_stack_ff <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // enables and float mode
  // ****************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      en_bkpt_ff <= 1'b0;
      en_sw_ff <= 1'b0;
      en_illegal_ff <= 1'b0;
      en_stack_ff <= 1'b0;
    end else if (dispatch.valid) begin
      en_bkpt_ff <= dispatch.bkpt_en;
      en_sw_ff <= dispatch.sw_en;
      en_illegal_ff <= dispatch.illegal_en;
      en_stack_ff <= dispatch.stack_en;
    end else if (wr_word1) begin
      en_bkpt_ff <= arf_req.wdata[`BIT_EN_BKPT];
      en_sw_ff <= arf_req.wdata[`BIT_EN_SW];
      en_illegal_ff <= arf_req.wdata[`BIT_EN_ILLEGAL];
      en_stack_ff <= arf_req.wdata[`BIT_EN_STACK];
    end
  end

  // the single-precision unit, the message sideband below and word 0 reads use this bit
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      single_float_mode_bit_ff <= 1'b0;
    end else if (dispatch.valid) begin
      single_float_mode_bit_ff <= dispatch.single_float_mode_bit;
    end else if (wr_word0) begin
      single_float_mode_bit_ff <= arf_req.wdata[`BIT_SINGLE_FLOAT_MODE_BIT];
    end
  end

  // follows the mode one cycle late; the switch control keeps
  // messages from leaving inside that cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      msg_float_sideband_ff <= 1'b0;
    end else begin
      msg_float_sideband_ff <= single_float_mode_bit_ff;
    end
  end

  // ****************************************************************
  // notification counts
  // ****************************************************************
  logic [THREAD_W-1:0] cnt_a;
  logic [HOST_W-1:0] cnt_host;
  logic [THREAD_W-1:0] cnt_b;
  logic [`NOTIFY_N-1:0] wait_hit;
  logic [`NOTIFY_N-1:0] restore_hit;

  always_comb begin
    wait_hit = '0;
    restore_hit = '0;
    if (wait_valid) begin
      wait_hit[wait_sel] = 1'b1;
    end
    if (nt_wr) begin
      unique case (arf_req.subreg)
        `SUB_WORD0: restore_hit[SEL_THREAD_A] = 1'b1;
        `SUB_WORD1: restore_hit[SEL_HOST] = 1'b1;
        `SUB_WORD2: restore_hit[SEL_THREAD_B] = 1'b1;
        default: restore_hit = '0;
      endcase
    end
  end

  // counts survive dispatch: reset clears them and restore writes load them
  notify_counter #(.WIDTH(THREAD_W)) u_count_a (
    .clock(clock),
    .rstn(rstn),
    .notify(notify_in[SEL_THREAD_A]),
    .wait_req(wait_hit[SEL_THREAD_A]),
    .restore_wr(restore_hit[SEL_THREAD_A]),
    .restore_data(arf_req.wdata[THREAD_W-1:0]),
    .count_ff(cnt_a),
    .stall_ff(wait_stall[SEL_THREAD_A])
  );

  notify_counter #(.WIDTH(HOST_W)) u_count_host (
    .clock(clock),
    .rstn(rstn),
    .notify(notify_in[SEL_HOST]),
    .wait_req(wait_hit[SEL_HOST]),
    .restore_wr(restore_hit[SEL_HOST]),
    .restore_data(arf_req.wdata[HOST_W-1:0]),
    .count_ff(cnt_host),
    .stall_ff(wait_stall[SEL_HOST])
  );

  notify_counter #(.WIDTH(THREAD_W)) u_count_b (
    .clock(clock),
    .rstn(rstn),
    .notify(notify_in[SEL_THREAD_B]),
    .wait_req(wait_hit[SEL_THREAD_B]),
    .restore_wr(restore_hit[SEL_THREAD_B]),
    .restore_data(arf_req.wdata[THREAD_W-1:0]),
    .count_ff(cnt_b),
    .stall_ff(wait_stall[SEL_THREAD_B])
  );

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [`DATA_W-1:0] nxt_rd_data;

  always_comb begin
    nxt_rd_data = `WORD_RESET;
    if (ctrl_sel && sub_known) begin
      unique case (arf_req.subreg)
        `SUB_WORD0: begin
          nxt_rd_data[`BIT_MASTER] = exc_mode_ff;
          nxt_rd_data[`BIT_SINGLE_FLOAT_MODE_BIT] = single_float_mode_bit_ff;
        end
        `SUB_WORD1: begin
          nxt_rd_data[`BIT_ST_HALT] = st_halt_ff;
          nxt_rd_data[`BIT_ST_SW] = st_sw_ff;
          nxt_rd_data[`BIT_ST_ILLEGAL] = st_illegal_ff;
          nxt_rd_data[`BIT_ST_STACK] = st_stack_ff;
          nxt_rd_data[`BIT_EN_BKPT] = en_bkpt_ff;
          nxt_rd_data[`BIT_EN_SW] = en_sw_ff;
          nxt_rd_data[`BIT_EN_ILLEGAL] = en_illegal_ff;
          nxt_rd_data[`BIT_EN_STACK] = en_stack_ff;
        end
        default: nxt_rd_data[`DATA_W-1:`AIP_LSB] = aip_ff;
      endcase
    end else if (notify_sel && sub_known) begin
      unique case (arf_req.subreg)
        `SUB_WORD0: nxt_rd_data[THREAD_W-1:0] = cnt_a;
        `SUB_WORD1: nxt_rd_data[HOST_W-1:0] = cnt_host;
        default: nxt_rd_data[THREAD_W-1:0] = cnt_b;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_data_ff <= `WORD_RESET;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= arf_req.valid && !arf_req.write;
      if (arf_req.valid && !arf_req.write) begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_return;
    ret ##1 (ip_load_ff && !exc_mode_ff);
  endsequence

  property p_return;
    @(posedge clock) disable iff (!rstn)
    ret |-> s_return ##0
      (ip_load_addr_ff == {$past(aip_ff), {`AIP_LSB{1'b0}}});
  endproperty
  a_return: assert property (p_return)
    else $error("return did not reload saved pointer");

  property p_entry;
    @(posedge clock) disable iff (!rstn)
    take |=> exc_mode_ff && ip_load_ff &&
      ip_load_addr_ff == $past(system_routine_entry_pointer);
  endproperty
  a_entry: assert property (p_entry)
    else $error("entry did not jump to system routine");

  property p_no_reentry;
    @(posedge clock) disable iff (!rstn)
    (exc_mode_ff && !ret) |=> !ip_load_ff;
  endproperty
  a_no_reentry: assert property (p_no_reentry)
    else $error("handler was re-entered");

  property p_sw_aip;
    @(posedge clock) disable iff (!rstn)
    (take && !take_sync) |=>
      aip_ff == $past(ip_field) + `AIP_ONE;
  endproperty
  a_sw_aip: assert property (p_sw_aip)
    else $error("software exception saved wrong pointer");

  property p_halt_status;
    @(posedge clock) disable iff (!rstn)
    exc_event.ext_halt |=> st_halt_ff;
  endproperty
  a_halt_status: assert property (p_halt_status)
    else $error("halt status not set");

  property p_disabled_recorded;
    @(posedge clock) disable iff (!rstn)
    (exc_event.illegal && !en_illegal_ff && !take) |=>
      st_illegal_ff && !ip_load_ff;
  endproperty
  a_disabled_recorded: assert property (p_disabled_recorded)
    else $error("disabled illegal opcode mishandled");

  property p_sideband;
    @(posedge clock) disable iff (!rstn)
    $changed(single_float_mode_bit_ff) |->
      ##1 msg_float_sideband_ff == $past(single_float_mode_bit_ff);
  endproperty
  a_sideband: assert property (p_sideband)
    else $error("sideband does not follow float mode");

  property p_reserved_read;
    @(posedge clock) disable iff (!rstn)
    (arf_req.valid && !arf_req.write && !sub_known) |=>
      rd_valid_ff && rd_data_ff == `WORD_RESET;
  endproperty
  a_reserved_read: assert property (p_reserved_read)
    else $error("reserved subregister read not zero");

  property p_count_ro;
    @(posedge clock) disable iff (!rstn)
    (notify_sel && arf_req.write && !arf_req.restore &&
      !wait_valid && notify_in == '0) |=> $stable(cnt_a);
  endproperty
  a_count_ro: assert property (p_count_ro)
    else $error("notification count written outside restore");

endmodule

// [bench/pipeline_model.sv]
// pipeline model that follows instruction pointer redirects
`timescale 1ns/100ps

module pipeline_model #(
  parameter logic [31:0] START_IP = 32'h0000_1000
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // redirect from the block
  input wire logic ip_load_ff,
  input wire logic [31:0] ip_load_addr_ff,
  // current pointer
  output logic [31:0] cur_ip_ff
);
  // the pointer stands still between redirects, so saved values are known
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cur_ip_ff <= START_IP;
    end else if (ip_load_ff) begin
      cur_ip_ff <= ip_load_addr_ff;
    end
  end
endmodule

// [bench/tb_top.sv]
// self-checking bench for the thread exception and notification block
`timescale 1ns/100ps
`include "exc_params.svh"

module tb_top;
  import exc_pkg::*;
  localparam logic [31:0] SYSTEM_ROUTINE_ENTRY_POINTER = 32'h0000_8000;
  localparam logic [3:0] CT = `REGTYPE_CTRL;
  localparam logic [3:0] NT = `REGTYPE_NOTIFY;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  arf_req_s arf_req = '0;
  dispatch_s dispatch = '0;
  exc_event_s exc_event = '0;
  logic [31:0] ip, rd_data_ff, ip_load_addr_ff, d;
  logic rd_valid_ff, ip_load_ff, exc_mode_ff, fm_ff, sb_ff;
  logic [2:0] notify_in = '0;
  logic wait_valid = 1'b0;
  notify_sel_e wait_sel = SEL_THREAD_A;
  logic [2:0] wait_stall;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;

  always #5 clock = ~clock;

  thread_exception_and_notify_regs dut (
    .clock(clock),
    .rstn(rstn),
    .arf_req(arf_req),
    .rd_data_ff(rd_data_ff),
    .rd_valid_ff(rd_valid_ff),
    .dispatch(dispatch),
    .exc_event(exc_event),
    .instruction_pointer(ip),
    .system_routine_entry_pointer(SYSTEM_ROUTINE_ENTRY_POINTER),
    .ip_load_ff(ip_load_ff),
    .ip_load_addr_ff(ip_load_addr_ff),
    .exc_mode_ff(exc_mode_ff),
    .single_float_mode_bit_ff(fm_ff),
    .msg_float_sideband_ff(sb_ff),
    .notify_in(notify_in),
    .wait_valid(wait_valid),
    .wait_sel(wait_sel),
    .wait_stall(wait_stall)
  );

  pipeline_model pipe (
    .clock(clock),
    .rstn(rstn),
    .ip_load_ff(ip_load_ff),
    .ip_load_addr_ff(ip_load_addr_ff),
    .cur_ip_ff(ip)
  );

  // ************************************************************
  // access tasks
  // ************************************************************
  task automatic chk(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one access per call, never overlapped, as a switch-marked op
  task automatic req(input logic wr, rs, input logic [3:0] t,
      input logic [4:0] s, input logic [31:0] w);
    @(posedge clock);
    arf_req <= '{1'b1, wr, rs, t, s, w};
    @(posedge clock);
    arf_req.valid <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] t, input logic [4:0] s);
    req(1'b0, 1'b0, t, s, 32'h0);
    chk("read valid", {31'h0, rd_valid_ff}, 32'h1);
    d = rd_data_ff;
  endtask

  task automatic ev(input exc_event_s e, input logic [2:0] n);
    @(posedge clock);
    exc_event <= e;
    notify_in <= n;
    @(posedge clock);
    exc_event <= '0;
    notify_in <= '0;
    #1;
  endtask

  task automatic wt(input notify_sel_e s);
    @(posedge clock);
    wait_valid <= 1'b1;
    wait_sel <= s;
    @(posedge clock);
    wait_valid <= 1'b0;
    #1;
  endtask

  task automatic disp();
    @(posedge clock);
    dispatch <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    @(posedge clock);
    dispatch.valid <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic end_sim();
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      end_sim();
    end
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(NT, 5'(4 * i));
      chk("notify reset", d, 32'h0);
    end
    rd(CT, 5'h00);
    chk("master reset", {31'h0, d[31]}, 32'h0);
    rd(CT, 5'h04);
    chk("status reset", d & 32'hffff_0000, 32'h0);
    disp();
    chk("float mode", {31'h0, fm_ff}, 32'h1);
    chk("sideband", {31'h0, sb_ff}, 32'h1);
    rd(CT, 5'h04);
    chk("enables", d, 32'h0000_b000);
    // one to master while clear is ignored; float bit follows software
    req(1'b1, 1'b0, CT, 5'h00, 32'h8000_0000);
    chk("no return", {31'h0, ip_load_ff}, 32'h0);
    rd(CT, 5'h00);
    chk("ctrl word", d, 32'h0);
    chk("sideband", {31'h0, sb_ff}, 32'h0);
    ev('{1'b0, 1'b0, 1'b1, 1'b0}, 3'h0);
    chk("entry", {ip_load_ff, exc_mode_ff}, 32'h3);
    chk("entry addr", ip_load_addr_ff, SYSTEM_ROUTINE_ENTRY_POINTER);
    rd(CT, 5'h08);
    chk("saved ptr", d, 32'h0000_1000);
    rd(CT, 5'h04);
    chk("status", d, 32'h1000_b000);
    req(1'b1, 1'b0, CT, 5'h08, 32'h0000_2000);
    req(1'b1, 1'b0, CT, 5'h00, 32'h0);
    chk("return", {ip_load_ff, exc_mode_ff}, 32'h2);
    chk("return addr", ip_load_addr_ff, 32'h0000_2000);
    // disabled stack overflow only records; left illegal status is inert
    ev('{1'b0, 1'b0, 1'b0, 1'b1}, 3'h0);
    chk("no entry", {ip_load_ff, exc_mode_ff}, 32'h0);
    rd(CT, 5'h04);
    chk("status", d, 32'h1800_b000);
    req(1'b1, 1'b0, CT, 5'h04, 32'h1800_b000);
    chk("zero sw bit", {31'h0, exc_mode_ff}, 32'h0);
    req(1'b1, 1'b0, CT, 5'h04, 32'h3800_b000);
    chk("sw entry", {ip_load_ff, exc_mode_ff}, 32'h3);
    rd(CT, 5'h08);
    chk("saved ptr", d, 32'h0000_2008);
    ev('{1'b0, 1'b1, 1'b0, 1'b0}, 3'h0);
    chk("in handler", {ip_load_ff, exc_mode_ff}, 32'h1);
    rd(CT, 5'h04);
    chk("status", d, 32'h7800_b000);
    req(1'b1, 1'b0, CT, 5'h04, 32'h0000_b000);
    rd(CT, 5'h04);
    chk("cleared", d, 32'h0000_b000);
    req(1'b1, 1'b0, CT, 5'h00, 32'h0);
    chk("return addr", ip_load_addr_ff, 32'h0000_2008);
    repeat (2) @(posedge clock);
    ev('{1'b1, 1'b0, 1'b0, 1'b0}, 3'h0);
    chk("bkpt entry", {31'h0, exc_mode_ff}, 32'h1);
    rd(CT, 5'h08);
    chk("saved ptr", d, 32'h0000_2008);
    req(1'b1, 1'b0, CT, 5'h00, 32'h0);
    chk("bkpt return", {ip_load_ff, exc_mode_ff}, 32'h2);
    // illegal opcode with its enable clear is only recorded
    req(1'b1, 1'b0, CT, 5'h04, 32'h0000_a000);
    ev('{1'b0, 1'b0, 1'b1, 1'b0}, 3'h0);
    chk("no entry", {ip_load_ff, exc_mode_ff}, 32'h0);
    rd(CT, 5'h04);
    chk("status", d, 32'h1000_a000);
    // notification words: restore only, masked widths, reserved codes
    req(1'b1, 1'b1, NT, 5'h00, 32'hffff_0002);
    req(1'b1, 1'b1, NT, 5'h04, 32'hffff_ffff);
    req(1'b1, 1'b0, NT, 5'h08, 32'h0000_0005);
    rd(NT, 5'h00);
    chk("count a", d, 32'h0000_0002);
    rd(NT, 5'h04);
    chk("host", d, 32'h0000_0001);
    rd(NT, 5'h08);
    chk("count b", d, 32'h0);
    rd(NT, 5'h0c);
    chk("reserved", d, 32'h0);
    wt(SEL_THREAD_A);
    rd(NT, 5'h00);
    chk("count a", d, 32'h0000_0001);
    wt(SEL_THREAD_A);
    wt(SEL_THREAD_A);
    chk("stall", {29'h0, wait_stall}, 32'h1);
    ev('0, 3'h1);
    chk("stall", {29'h0, wait_stall}, 32'h0);
    rd(NT, 5'h00);
    chk("count a", d, 32'h0);
    disp();
    rd(NT, 5'h04);
    chk("host kept", d, 32'h0000_0001);
    wt(SEL_HOST);
    rd(NT, 5'h04);
    chk("host", d, 32'h0);
    ev('0, 3'h4);
    rd(NT, 5'h08);
    chk("count b", d, 32'h0000_0001);
    end_sim();
  end
endmodule
